/* File: hw/rie_consts.svh */
// Constants for the RAM instruction engine
`ifndef RIE_CONSTS_SVH
`define RIE_CONSTS_SVH
`define RIE_RAM_BYTES  768
`define RIE_AW         10
`define RIE_CW         8
`define RIE_BLK        16
`define RIE_ROUNDS     4'hA
`define RIE_RCON0      8'h01
`define RIE_AFFINE     8'h63
`define RIE_GF_POLY    8'h1B
`define RIE_REV_SAFE   16
`define RIE_MFLAG_LSB  3
`define RIE_FIFO_DEPTH 8
`endif

/* File: hw/rie_pkg.sv */
// Types for the RAM instruction engine
`include "rie_consts.svh"
package rie_pkg;
  typedef enum logic [3:0] {
    OP_RX_MOVE  = 4'h1,
    OP_TX_COPY  = 4'h2,
    OP_COPY     = 4'h3,
    OP_COPY_REV = 4'h4,
    OP_XOR      = 4'h5,
    OP_INC      = 4'h6,
    OP_ENC      = 4'h7,
    OP_ENC_INPL = 4'h8,
    OP_ENC_XOR  = 4'h9,
    OP_CTR      = 4'hA,
    OP_CBC_MAC  = 4'hB
  } rie_op_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_PREP  = 7'h02,
    S_BYTE  = 7'h04,
    S_CIPH  = 7'h08,
    S_STORE = 7'h10,
    S_CINC  = 7'h20,
    S_DONE  = 7'h40
  } rie_state_t;

  typedef struct packed {
    rie_op_t               op;
    logic [`RIE_CW-1:0]    cnt;
    logic [`RIE_AW-1:0]    src;
    logic [`RIE_AW-1:0]    dst;
    logic [`RIE_AW-1:0]    key;
    logic [`RIE_AW-1:0]    ctr;
    logic [2:0]            m;
  } rie_instr_t;

  typedef struct packed {
    logic                  en;
    logic                  we;
    logic [`RIE_AW-1:0]    addr;
    logic [7:0]            wdata;
  } rie_ram_req_t;
endpackage : rie_pkg

/* File: hw/rie_fifo.sv */
// Byte FIFO between the engine and the transmit output
`timescale 1ns/100ps
module rie_fifo #(
  parameter int W = 8,
  parameter int D = `RIE_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : rie_fifo

/* File: hw/rie_engine.sv */
// RAM instruction engine: memory moves, byte ops and AES-128 encryption
`timescale 1ns/100ps
module rie_engine (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  // Instruction port
  input  wire logic                  ins_valid,
  output logic                       ins_ready,
  input  wire rie_pkg::rie_instr_t   ins,
  output logic                       done,
  output logic                       busy,
  // Host RAM access
  input  wire rie_pkg::rie_ram_req_t ram_req,
  output logic [7:0]                 ram_rdata,
  // Receive stream
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  output logic                       rx_ready,
  // Transmit stream
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic [7:0]                 tx_data
);
  logic [7:0]              ram [`RIE_RAM_BYTES];
  rie_pkg::rie_state_t     st_q;
  rie_pkg::rie_instr_t     ins_q;
  logic [7:0]              n_q;
  logic [7:0]              base_q;
  logic                    carry_q;
  logic                    dn_q;
  logic                    first_q;
  logic [127:0]            aes_q;
  logic [127:0]            rk_q;
  logic [7:0]              rcon_q;
  logic [3:0]              rnd_q;
  logic [7:0]              idx;
  logic [4:0]              bl;
  logic [4:0]              wlen;
  logic                    more;
  logic                    step;
  logic                    f_in_ready;
  logic [`RIE_AW-1:0]      ra;
  logic [`RIE_AW-1:0]      wa;
  logic [7:0]              rd_a;
  logic [7:0]              rd_b;
  logic                    eng_we;
  logic [7:0]              eng_wd;
  logic [7:0]              res_b;
  logic [8:0]              inc_s;
  logic [127:0]            gat;
  logic [127:0]            kg;
  logic [127:0]            blk_in;
  logic [127:0]            rkn;
  logic [127:0]            rnd_o;
  logic [4:0]              micl;
  logic                    idle;

  function automatic logic [`RIE_AW-1:0] ad(input logic [`RIE_AW-1:0] a,
                                            input logic [`RIE_AW-1:0] o);
    logic [`RIE_AW:0] s;
    s = {1'b0, a} + {1'b0, o};
    if (s >= (`RIE_AW+1)'(`RIE_RAM_BYTES)) begin
      s = s - (`RIE_AW+1)'(`RIE_RAM_BYTES);
    end
    return s[`RIE_AW-1:0];
  endfunction : ad

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? `RIE_GF_POLY : 8'h00);
  endfunction : xt

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = xt(x);
    end
    return p;
  endfunction : gmul

  // Substitution box from the field inverse x^254 and the affine map
  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] s;
    r = 8'h01;
    s = a;
    for (int i = 0; i < 7; i++) begin
      s = gmul(s, s);
      r = gmul(r, s);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
             ^ {r[3:0], r[7:4]} ^ `RIE_AFFINE;
  endfunction : sb

  function automatic logic [2:0] mval(input logic [1:0] m);
    case (m)
      2'h0:    return 3'h0;
      2'h1:    return 3'h1;
      2'h2:    return 3'h3;
      default: return 3'h7;
    endcase
  endfunction : mval

  function automatic logic is_enc(input rie_pkg::rie_op_t op);
    return op == rie_pkg::OP_ENC || op == rie_pkg::OP_ENC_INPL || op == rie_pkg::OP_ENC_XOR;
  endfunction : is_enc

  assign idle      = st_q == rie_pkg::S_IDLE;
  assign ins_ready = idle;
  assign busy      = !idle;
  assign done      = st_q == rie_pkg::S_DONE;
  assign rx_ready  = st_q == rie_pkg::S_BYTE && ins_q.op == rie_pkg::OP_RX_MOVE;
  assign idx       = dn_q ? ins_q.cnt - 8'h01 - n_q : n_q;
  assign bl        = ((ins_q.cnt - base_q) >= 8'h10) ? 5'h10 : 5'(ins_q.cnt - base_q);
  assign more      = ({1'b0, base_q} + 9'h010) < {1'b0, ins_q.cnt};
  assign micl      = (ins_q.m[1:0] == 2'h0) ? 5'h00 : 5'(5'h02 << ins_q.m[1:0]);
  assign rd_a      = ram[ra];
  assign rd_b      = ram[wa];
  assign res_b     = aes_q[127 - 8*n_q[3:0] -: 8];
  assign inc_s     = {1'b0, rd_a} + {8'h00, carry_q};

  always_comb begin
    case (ins_q.op)
      rie_pkg::OP_RX_MOVE: step = rx_valid;
      rie_pkg::OP_TX_COPY: step = f_in_ready;
      default:             step = 1'b1;
    endcase
  end

  always_comb begin
    case (ins_q.op)
      rie_pkg::OP_COPY_REV: wlen = bl;
      rie_pkg::OP_CTR:      wlen = bl;
      rie_pkg::OP_CBC_MAC:  wlen = micl;
      default:              wlen = 5'h10;
    endcase
  end

  // Read and write addresses for byte ops, stores and counter bumps
  always_comb begin
    ra = ad(ins_q.src, {2'h0, idx});
    wa = ad(ins_q.dst, {2'h0, idx});
    case (st_q)
      rie_pkg::S_BYTE: begin
        if (ins_q.op == rie_pkg::OP_INC) begin
          wa = ra;
        end
      end
      rie_pkg::S_STORE: begin
        ra = ad(ins_q.src, {2'h0, base_q + n_q});
        case (ins_q.op)
          rie_pkg::OP_COPY_REV: wa = ad(ins_q.dst, {2'h0, ins_q.cnt - 8'h01 - base_q - n_q});
          rie_pkg::OP_ENC_INPL: wa = ad(ins_q.src, {2'h0, n_q});
          rie_pkg::OP_CTR:      wa = ad(ins_q.dst, {2'h0, base_q + n_q});
          default:              wa = ad(ins_q.dst, {2'h0, n_q});
        endcase
      end
      rie_pkg::S_CINC: begin
        ra = ad(ins_q.ctr, {2'h0, n_q});
        wa = ra;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    eng_we = 1'b0;
    eng_wd = rd_a;
    case (st_q)
      rie_pkg::S_BYTE: begin
        eng_we = step && ins_q.op != rie_pkg::OP_TX_COPY;
        case (ins_q.op)
          rie_pkg::OP_RX_MOVE: eng_wd = rx_data;
          rie_pkg::OP_XOR:     eng_wd = rd_a ^ rd_b;
          rie_pkg::OP_INC:     eng_wd = inc_s[7:0];
          default:             eng_wd = rd_a;
        endcase
      end
      rie_pkg::S_STORE: begin
        eng_we = 1'b1;
        case (ins_q.op)
          rie_pkg::OP_ENC_XOR: eng_wd = rd_b ^ res_b;
          rie_pkg::OP_CTR:     eng_wd = rd_a ^ res_b;
          default:             eng_wd = res_b;
        endcase
      end
      rie_pkg::S_CINC: begin
        eng_we = 1'b1;
        eng_wd = inc_s[7:0];
      end
      default: begin
      end
    endcase
  end

  // Block gather; key and counter are stored byte-reversed
  always_comb begin
    logic       rev;
    logic [7:0] o;
    rev = ins_q.op == rie_pkg::OP_CTR || (ins_q.op == rie_pkg::OP_CBC_MAC && first_q);
    o   = 8'h00;
    gat = '0;
    kg  = '0;
    for (int i = 0; i < 16; i++) begin
      o = rev ? 8'(15 - i) : 8'(i);
      kg[127-8*i -: 8] = ram[ad(ins_q.key, 10'(15 - i))];
      if (rev) begin
        gat[127-8*i -: 8] = ram[ad(ins_q.ctr, {2'h0, o})];
      end else if (5'(i) < bl) begin
        gat[127-8*i -: 8] = ram[ad(ins_q.src, {2'h0, base_q + o})];
      end
    end
    blk_in = gat;
    if (ins_q.op == rie_pkg::OP_CBC_MAC) begin
      if (first_q) begin
        blk_in[120+`RIE_MFLAG_LSB +: 3] = mval(ins_q.m[1:0]);
      end else begin
        blk_in = gat ^ aes_q;
      end
    end
  end

  // One AES-128 encryption round with on-the-fly key expansion
  always_comb begin
    logic [127:0] sh;
    logic [127:0] mx;
    logic [31:0]  t;
    logic [7:0]   a0;
    logic [7:0]   a1;
    logic [7:0]   a2;
    logic [7:0]   a3;
    a0 = 8'h00;
    a1 = 8'h00;
    a2 = 8'h00;
    a3 = 8'h00;
    t = {sb(rk_q[23:16]), sb(rk_q[15:8]), sb(rk_q[7:0]), sb(rk_q[31:24])};
    t = t ^ {rcon_q, 24'h000000};
    rkn[127:96] = rk_q[127:96] ^ t;
    rkn[95:64]  = rk_q[95:64] ^ rkn[127:96];
    rkn[63:32]  = rk_q[63:32] ^ rkn[95:64];
    rkn[31:0]   = rk_q[31:0] ^ rkn[63:32];
    sh = '0;
    mx = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        sh[127-8*(4*c+r) -: 8] = sb(aes_q[127-8*(4*((c+r)%4)+r) -: 8]);
      end
      a0 = sh[127-32*c -: 8];
      a1 = sh[119-32*c -: 8];
      a2 = sh[111-32*c -: 8];
      a3 = sh[103-32*c -: 8];
      mx[127-32*c -: 8] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
      mx[119-32*c -: 8] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
      mx[111-32*c -: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
      mx[103-32*c -: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
    end
    rnd_o = ((rnd_q == `RIE_ROUNDS) ? sh : mx) ^ rkn;
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= rie_pkg::S_IDLE;
    end else if (ce) begin
      case (st_q)
        rie_pkg::S_IDLE: begin
          if (ins_valid) begin
            st_q <= rie_pkg::S_PREP;
          end
        end
        rie_pkg::S_PREP: begin
          if (is_enc(ins_q.op) || ins_q.op == rie_pkg::OP_CBC_MAC) begin
            st_q <= rie_pkg::S_CIPH;
          end else if (ins_q.cnt == 8'h00) begin
            st_q <= rie_pkg::S_DONE;
          end else if (ins_q.op == rie_pkg::OP_CTR) begin
            st_q <= rie_pkg::S_CIPH;
          end else if (ins_q.op == rie_pkg::OP_COPY_REV) begin
            st_q <= rie_pkg::S_STORE;
          end else begin
            st_q <= rie_pkg::S_BYTE;
          end
        end
        rie_pkg::S_BYTE: begin
          if (step && n_q == ins_q.cnt - 8'h01) begin
            st_q <= rie_pkg::S_DONE;
          end
        end
        rie_pkg::S_CIPH: begin
          if (rnd_q == `RIE_ROUNDS) begin
            if (ins_q.op != rie_pkg::OP_CBC_MAC) begin
              st_q <= rie_pkg::S_STORE;
            end else if ((first_q && ins_q.cnt != 8'h00) || (!first_q && more)) begin
              st_q <= rie_pkg::S_PREP;
            end else begin
              st_q <= (micl == 5'h00) ? rie_pkg::S_DONE : rie_pkg::S_STORE;
            end
          end
        end
        rie_pkg::S_STORE: begin
          if (n_q == 8'(wlen - 5'h01)) begin
            if (ins_q.op == rie_pkg::OP_CTR) begin
              st_q <= rie_pkg::S_CINC;
            end else if (ins_q.op == rie_pkg::OP_COPY_REV && more) begin
              st_q <= rie_pkg::S_PREP;
            end else begin
              st_q <= rie_pkg::S_DONE;
            end
          end
        end
        rie_pkg::S_CINC: begin
          if (n_q == 8'h01) begin
            st_q <= more ? rie_pkg::S_PREP : rie_pkg::S_DONE;
          end
        end
        default: st_q <= rie_pkg::S_IDLE;
      endcase
    end
  end

  // Instruction capture and block bookkeeping
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ins_q   <= '0;
      dn_q    <= 1'b0;
      base_q  <= 8'h00;
      first_q <= 1'b0;
    end else if (ce) begin
      if (idle && ins_valid) begin
        ins_q   <= ins;
        dn_q    <= (ins.op == rie_pkg::OP_COPY || ins.op == rie_pkg::OP_XOR) && ins.dst > ins.src;
        base_q  <= 8'h00;
        first_q <= 1'b1;
      end
      if (st_q == rie_pkg::S_CIPH && rnd_q == `RIE_ROUNDS && ins_q.op == rie_pkg::OP_CBC_MAC) begin
        first_q <= 1'b0;
        if (!first_q) begin
          base_q <= base_q + 8'h10;
        end
      end
      if ((st_q == rie_pkg::S_STORE && ins_q.op == rie_pkg::OP_COPY_REV
           && n_q == 8'(wlen - 5'h01)) || (st_q == rie_pkg::S_CINC && n_q == 8'h01)) begin
        base_q <= base_q + 8'h10;
      end
    end
  end

  // Byte index and carry
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      n_q     <= 8'h00;
      carry_q <= 1'b0;
    end else if (ce) begin
      case (st_q)
        rie_pkg::S_BYTE: begin
          if (step) begin
            n_q     <= n_q + 8'h01;
            carry_q <= inc_s[8];
          end
        end
        rie_pkg::S_STORE: begin
          n_q     <= (n_q == 8'(wlen - 5'h01)) ? 8'h00 : n_q + 8'h01;
          carry_q <= 1'b1;
        end
        rie_pkg::S_CINC: begin
          n_q     <= (n_q == 8'h01) ? 8'h00 : n_q + 8'h01;
          carry_q <= inc_s[8];
        end
        default: begin
          n_q     <= 8'h00;
          carry_q <= 1'b1;
        end
      endcase
    end
  end

  // Cipher datapath
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aes_q  <= '0;
      rk_q   <= '0;
      rcon_q <= `RIE_RCON0;
      rnd_q  <= 4'h1;
    end else if (ce) begin
      if (st_q == rie_pkg::S_PREP) begin
        aes_q  <= (ins_q.op == rie_pkg::OP_COPY_REV) ? gat : blk_in ^ kg;
        rk_q   <= kg;
        rcon_q <= `RIE_RCON0;
        rnd_q  <= 4'h1;
      end else if (st_q == rie_pkg::S_CIPH) begin
        aes_q  <= rnd_o;
        rk_q   <= rkn;
        rcon_q <= xt(rcon_q);
        rnd_q  <= rnd_q + 4'h1;
      end
    end
  end

  // RAM write port; host access only while idle
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (eng_we) begin
        ram[wa] <= eng_wd;
      end else if (idle && ram_req.en && ram_req.we) begin
        ram[ad(ram_req.addr, 10'h000)] <= ram_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ram_rdata <= 8'h00;
    end else if (ce && idle && ram_req.en && !ram_req.we) begin
      ram_rdata <= ram[ad(ram_req.addr, 10'h000)];
    end
  end

  rie_fifo #(
    .W (8),
    .D (`RIE_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (st_q == rie_pkg::S_BYTE && ins_q.op == rie_pkg::OP_TX_COPY),
    .in_ready  (f_in_ready),
    .in_data   (rd_a),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
endmodule : rie_engine

/* File: bench/rie_engine_sva.sv */
// Port checker for the RAM instruction engine
`timescale 1ns/100ps
module rie_engine_sva (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               ce,
  // Instruction port
  input wire logic               ins_valid,
  input wire logic               ins_ready,
  input wire rie_pkg::rie_instr_t ins,
  input wire logic               done,
  input wire logic               busy,
  // Streams
  input wire logic               rx_valid,
  input wire logic               rx_ready,
  input wire logic               tx_valid,
  input wire logic               tx_ready,
  input wire logic [7:0]         tx_data
);
  logic       take;
  logic       on_q;
  logic [8:0] n_q;
  logic [8:0] e_q;
  assign take = ce && ins_valid && ins_ready;
  // Cycles since an instruction was taken; on_q marks a plain copy
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      on_q <= 1'b0;
      n_q  <= 9'h000;
      e_q  <= 9'h000;
    end else if (ce) begin
      if (take) begin
        on_q <= (ins.op == rie_pkg::OP_COPY);
        n_q  <= 9'h001;
        e_q  <= 9'h002 + 9'(ins.cnt);
      end else if (done) begin
        on_q <= 1'b0;
      end else begin
        n_q <= n_q + 9'h001;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ready_busy_a: assert property (ins_ready != busy)
    else $error("ready and busy disagree");
  take_busy_a: assert property (take |=> busy)
    else $error("no busy after take");
  done_pulse_a: assert property (done && ce |=> !done)
    else $error("done longer than one cycle");
  done_idle_a: assert property (done && ce |=> ins_ready)
    else $error("not ready after done");
  done_busy_a: assert property (done |-> busy)
    else $error("done outside busy");
  enc_time_a: assert property (take && ins.op inside {rie_pkg::OP_ENC,
    rie_pkg::OP_ENC_INPL, rie_pkg::OP_ENC_XOR} |=> !done [*8] ##20 done)
    else $error("encrypt latency wrong");
  copy_time_a: assert property (on_q && done |-> n_q == e_q)
    else $error("copy latency wrong");
  rx_idle_a: assert property (!busy |-> !rx_ready)
    else $error("receive ready while idle");
  tx_hold_a: assert property (tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data))
    else $error("transmit byte lost under stall");
  cover property (take && ins.op == rie_pkg::OP_ENC);
  cover property (tx_valid && !tx_ready);
  cover property (rx_valid && rx_ready);
endmodule : rie_engine_sva

bind rie_engine rie_engine_sva chk (.clk_sys, .rstn, .ce, .ins_valid, .ins_ready, .ins,
  .done, .busy, .rx_valid, .rx_ready, .tx_valid, .tx_ready, .tx_data);

/* File: bench/rie_stream_peer.sv */
// Receive source and stalling transmit sink
`timescale 1ns/100ps
module rie_stream_peer (
  // Clock and reset
  input wire logic  clk_sys,
  input wire logic  rstn,
  // Control
  input wire logic  rx_en,
  input wire logic  stall,
  // Receive stream
  output logic       rx_valid,
  output logic [7:0] rx_data,
  input wire logic   rx_ready,
  // Transmit stream
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  output logic           tx_ready
);
  logic [7:0] rx_idx;
  logic [1:0] ph;
  logic       en_q;
  logic       st_q;
  logic [7:0] tx_log [0:15];
  int         tx_cnt;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_idx <= 8'h00;
      tx_cnt <= 0;
      ph     <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (rx_valid && rx_ready) rx_idx <= rx_idx + 8'h01;
      if (tx_valid && tx_ready) begin
        tx_log[tx_cnt[3:0]] <= tx_data;
        tx_cnt <= tx_cnt + 1;
      end
    end
    en_q <= rx_en;
    st_q <= stall;
  end
  // Idle data toggles so it never looks held
  always @(negedge clk_sys) begin
    rx_valid <= en_q && (!st_q || ph[0]);
    rx_data  <= (en_q && (!st_q || ph[0])) ? 8'hA0 + rx_idx : ~rx_data;
    tx_ready <= !st_q || (ph == 2'h3);
  end
endmodule : rie_stream_peer

/* File: bench/test_ram_instruction_engine.sv */
// Testbench for the RAM instruction engine
`timescale 1ns/100ps
module test_ram_instruction_engine;
  logic                  clk_sys, rstn, ce, ins_valid, rx_en, stall;
  rie_pkg::rie_instr_t   ins;
  rie_pkg::rie_ram_req_t ram_req;
  logic                  ins_ready, done, busy, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]            ram_rdata, rx_data, tx_data;
  int                    fails, check_count, cyc;
  logic [2:0]            mlen;
  rie_engine dut (.clk_sys, .rstn, .ce, .ins_valid, .ins_ready, .ins, .done, .busy,
    .ram_req, .ram_rdata, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_ready, .tx_data);
  rie_stream_peer peer (.clk_sys, .rstn, .rx_en, .stall, .rx_valid, .rx_data, .rx_ready,
    .tx_valid, .tx_data, .tx_ready);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [9:0] a, input logic [7:0] d);
    ram_req = '{1'b1, 1'b1, a, d};
    @(negedge clk_sys);
  endtask : wr
  task fill(input logic [9:0] a, input int n, input logic [7:0] b, input logic [7:0] s);
    for (int i = 0; i < n; i++) wr(10'(a + i), 8'(b + s * i));
  endtask : fill
  task rd(input logic [9:0] a, output logic [7:0] d);
    ram_req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk_sys);
    d = ram_rdata;
  endtask : rd
  task at(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(d, e);
  endtask : at
  task run(input rie_pkg::rie_op_t op, input logic [7:0] c, input logic [9:0] a, e, k, n);
    ram_req   = '0;
    ins       = '{op, c, a, e, k, n, mlen};
    ins_valid = 1'b1;
    @(negedge clk_sys);
    ins_valid = 1'b0;
    for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge clk_sys);
    check(8'(done), 8'h01);
    @(negedge clk_sys);
  endtask : run
  task t_copy;
    fill(10'h22A, 9, 8'h30, 8'h01);
    // Frozen engine must not take an offered clear
    ce        = 1'b0;
    ins       = '{rie_pkg::OP_XOR, 8'h01, 10'h22A, 10'h22A, 10'h000, 10'h000, 3'h0};
    ins_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(8'(busy), 8'h00);
    ins_valid = 1'b0;
    ce        = 1'b1;
    @(negedge clk_sys);
    run(rie_pkg::OP_COPY, 8'h09, 10'h22A, 10'h22B, 10'h000, 10'h000);
    at(10'h22A, 8'h30);
    for (int i = 1; i < 10; i++) at(10'(10'h22A + i), 8'(8'h2F + i));
    $display("test copy done");
  endtask : t_copy
  task t_rev;
    fill(10'h040, 16, 8'h50, 8'h01);
    run(rie_pkg::OP_COPY_REV, 8'h10, 10'h040, 10'h044, 10'h000, 10'h000);
    for (int n = 0; n < 16; n++) at(10'(10'h053 - n), 8'(8'h50 + n));
    $display("test reversed copy done");
  endtask : t_rev
  task t_xor;
    fill(10'h080, 4, 8'hF0, 8'h01);
    fill(10'h090, 4, 8'h00, 8'h03);
    run(rie_pkg::OP_XOR, 8'h04, 10'h080, 10'h090, 10'h000, 10'h000);
    for (int i = 0; i < 4; i++) at(10'(10'h090 + i), 8'((8'hF0 + i) ^ (3 * i)));
    run(rie_pkg::OP_XOR, 8'h04, 10'h090, 10'h090, 10'h000, 10'h000);
    for (int i = 0; i < 4; i++) at(10'(10'h090 + i), 8'h00);
    $display("test xor done");
  endtask : t_xor
  task t_inc;
    logic [7:0]  cs [3];
    logic [9:0]  as [3];
    logic [31:0] ex [3];
    cs = '{8'h02, 8'h04, 8'h01};
    as = '{10'h0A0, 10'h0A0, 10'h0A2};
    ex = '{32'h00120000, 32'h00120001, 32'h00130001};
    fill(10'h0A0, 2, 8'hFF, 8'h00);
    wr(10'h0A2, 8'h12);
    wr(10'h0A3, 8'h00);
    for (int s = 0; s < 3; s++) begin
      run(rie_pkg::OP_INC, cs[s], as[s], 10'h000, 10'h000, 10'h000);
      for (int b = 0; b < 4; b++) at(10'(10'h0A0 + b), ex[s][8*b+:8]);
    end
    $display("test increment done");
  endtask : t_inc
  task t_stream;
    fill(10'h100, 12, 8'h10, 8'h01);
    rx_en = 1'b1;
    stall = 1'b1;
    run(rie_pkg::OP_RX_MOVE, 8'h04, 10'h000, 10'h100, 10'h000, 10'h000);
    rx_en = 1'b0;
    run(rie_pkg::OP_TX_COPY, 8'h0C, 10'h100, 10'h000, 10'h000, 10'h000);
    for (int i = 0; i < 200 && peer.tx_cnt < 12; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (int i = 0; i < 12; i++) check(peer.tx_log[i], 8'(i < 4 ? 8'hA0 + i : 8'h10 + i));
    check(8'(tx_valid), 8'h00);
    stall = 1'b0;
    $display("test streams done");
  endtask : t_stream
  task t_enc;
    logic [7:0]   r;
    logic [127:0] kat;
    kat = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    fill(10'h180, 16, 8'h0F, 8'hFF);
    fill(10'h1B0, 16, 8'h00, 8'h11);
    run(rie_pkg::OP_ENC, 8'h10, 10'h1B0, 10'h1B0, 10'h180, 10'h000);
    for (int i = 0; i < 16; i++) at(10'(10'h1B0 + i), kat[127-8*i -: 8]);
    fill(10'h1A0, 4, 8'h01, 8'h01);
    fill(10'h1A4, 12, 8'h00, 8'h00);
    fill(10'h1E0, 16, 8'h5A, 8'h00);
    fill(10'h200, 4, 8'h01, 8'h01);
    fill(10'h204, 12, 8'hEE, 8'h00);
    run(rie_pkg::OP_ENC, 8'h10, 10'h1A0, 10'h1C0, 10'h180, 10'h000);
    run(rie_pkg::OP_ENC_XOR, 8'h10, 10'h1A0, 10'h1E0, 10'h180, 10'h000);
    run(rie_pkg::OP_ENC_INPL, 8'h04, 10'h200, 10'h200, 10'h180, 10'h000);
    for (int i = 0; i < 16; i++) begin
      rd(10'(10'h1C0 + i), r);
      at(10'(10'h1E0 + i), r ^ 8'h5A);
      at(10'(10'h200 + i), r);
    end
    $display("test encrypt done");
  endtask : t_enc
  task t_ctr;
    fill(10'h240, 16, 8'h00, 8'h00);
    wr(10'h240, 8'hFF);
    run(rie_pkg::OP_CTR, 8'h20, 10'h260, 10'h2A0, 10'h180, 10'h240);
    at(10'h240, 8'h01);
    at(10'h241, 8'h01);
    at(10'h242, 8'h00);
    $display("test counter mode done");
  endtask : t_ctr
  task t_mac;
    logic [7:0] r;
    fill(10'h2C0, 15, 8'h61, 8'h01);
    wr(10'h2CF, 8'hC7);
    fill(10'h2E0, 16, 8'h70, 8'hFF);
    wr(10'h2E0, 8'hDF);
    run(rie_pkg::OP_ENC, 8'h10, 10'h2E0, 10'h2F0, 10'h180, 10'h000);
    mlen = 3'h2;
    run(rie_pkg::OP_CBC_MAC, 8'h00, 10'h000, 10'h000, 10'h180, 10'h2C0);
    mlen = 3'h0;
    for (int i = 0; i < 8; i++) begin
      rd(10'(10'h2F0 + i), r);
      at(10'(10'h000 + i), r);
    end
    $display("test authentication done");
  endtask : t_mac
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    ins_valid = 1'b0;
    ins = '0;
    ram_req = '0;
    rx_en = 1'b0;
    stall = 1'b0;
    fails = 0;
    check_count = 0;
    cyc = 0;
    mlen = 3'h0;
    repeat (4) @(negedge clk_sys);
    check(8'({ins_ready, busy, done, rx_ready, tx_valid}), 8'h10);
    rstn = 1'b1;
    @(negedge clk_sys);
    t_copy();
    t_rev();
    t_xor();
    t_inc();
    t_stream();
    t_enc();
    t_ctr();
    t_mac();
    complete_run();
  end
endmodule : test_ram_instruction_engine
